// *** rtl/rtmon_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtmon_top #(
    parameter int unsigned OPEN_MIN_CYC = rtmon_pkg::OPEN_MIN_CYC,
    parameter int unsigned MON_OPEN_CYC = rtmon_pkg::MON_OPEN_CYC,
    parameter bit LATCH_MODEL = 1'b1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // shared reset, test and monitoring pin
    input wire logic reset_test_in,
    // beam evaluation from the scanner
    input wire logic beams_clear,
    input wire logic fault_detect,
    // safety outputs and status
    output logic safety_switch_output_1,
    output logic safety_switch_output_2,
    output logic test_active,
    output logic lockout,
    output logic wait_reset
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic safety_switch_output;
        logic [4:0] st_cnt;
        rtmon_pkg::rtmon_state_t st;
    } rtmon_top_t;
    rtmon_top_t s_reg;
    rtmon_top_t s_next;

    localparam logic [rtmon_pkg::CNT_W-1:0] LONG_LIM =
        rtmon_pkg::CNT_W'(OPEN_MIN_CYC);
    localparam logic [rtmon_pkg::CNT_W-1:0] MON_LIM =
        rtmon_pkg::CNT_W'(MON_OPEN_CYC);
    localparam logic [4:0] ST_LIM = 5'(rtmon_pkg::SELFTEST_CYC);
    // edges before the synchronised pin shows the real input
    localparam logic [4:0] PWR_SETTLE = 5'(rtmon_pkg::SYNC_SETTLE_CYC);

    logic long_open;
    logic mon_open;
    logic released_long;

    ////////////////////////////////////////////////////////////////////
    // opening timer on the synchronised shared input
    rtmon_open_timer #(
        .W(rtmon_pkg::CNT_W)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .line_high(s_reg.sync2),
        .long_lim(LONG_LIM),
        .mon_lim(MON_LIM),
        .long_open(long_open),
        .mon_open(mon_open),
        .released_long(released_long)
    );

    ////////////////////////////////////////////////////////////////////
    // state machine: one input, meaning chosen by state
    always_comb
    begin
        s_next = s_reg;
        s_next.sync1 = reset_test_in;
        s_next.sync2 = s_reg.sync1;
        case (s_reg.st)
            rtmon_pkg::RTMON_ST_POWERUP:
            begin
                // wait for the synchroniser to fill before judging the
                // pin, else its reset value would decide the outcome
                if (s_reg.st_cnt != PWR_SETTLE)
                    s_next.st_cnt = s_reg.st_cnt + 5'h01;
                // low or floating input at power-up locks out
                else if (!s_reg.sync2)
                    s_next.st = rtmon_pkg::RTMON_ST_LOCKOUT;
                else if (LATCH_MODEL)
                    s_next.st = rtmon_pkg::RTMON_ST_WAIT_RESET;
                else
                    s_next.st = rtmon_pkg::RTMON_ST_TRIPPED;
            end
            rtmon_pkg::RTMON_ST_WAIT_RESET, rtmon_pkg::RTMON_ST_LOCKOUT:
            begin
                // long opening then close is a reset
                if (released_long && !fault_detect)
                    s_next.st = rtmon_pkg::RTMON_ST_TRIPPED;
            end
            rtmon_pkg::RTMON_ST_TRIPPED:
            begin
                if (fault_detect)
                    s_next.st = rtmon_pkg::RTMON_ST_LOCKOUT;
                else if (beams_clear && s_reg.sync2)
                    s_next.st = rtmon_pkg::RTMON_ST_RUN;
            end
            rtmon_pkg::RTMON_ST_RUN:
            begin
                // contact loop open too long or test opening
                if (fault_detect)
                    s_next.st = rtmon_pkg::RTMON_ST_LOCKOUT;
                else if (mon_open || long_open)
                begin
                    s_next.st = rtmon_pkg::RTMON_ST_TEST;
                    s_next.st_cnt = '0;
                end
                else if (!beams_clear)
                    s_next.st = LATCH_MODEL ?
                        rtmon_pkg::RTMON_ST_WAIT_RESET :
                        rtmon_pkg::RTMON_ST_TRIPPED;
            end
            rtmon_pkg::RTMON_ST_TEST:
            begin
                // self-test runs, then waits for the input to close
                if (s_reg.st_cnt != ST_LIM)
                    s_next.st_cnt = s_reg.st_cnt + 5'h01;
                else if (fault_detect)
                    s_next.st = rtmon_pkg::RTMON_ST_LOCKOUT;
                else if (s_reg.sync2)
                    s_next.st = rtmon_pkg::RTMON_ST_TRIPPED;
            end
            default:
                s_next.st = rtmon_pkg::RTMON_ST_LOCKOUT;
        endcase
        // outputs on only when entering or staying in run
        s_next.safety_switch_output = (s_next.st == rtmon_pkg::RTMON_ST_RUN);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.st <= rtmon_pkg::RTMON_ST_POWERUP;
            // synchroniser starts at the closed level: no false opening
            s_reg.sync1 <= 1'b1;
            s_reg.sync2 <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    assign safety_switch_output_1 = s_reg.safety_switch_output;
    assign safety_switch_output_2 = s_reg.safety_switch_output;
    assign test_active = (s_reg.st == rtmon_pkg::RTMON_ST_TEST);
    assign lockout = (s_reg.st == rtmon_pkg::RTMON_ST_LOCKOUT);
    assign wait_reset = (s_reg.st == rtmon_pkg::RTMON_ST_WAIT_RESET);

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_pwrup_low_lock: assert property (
        s_reg.st == rtmon_pkg::RTMON_ST_POWERUP && !s_reg.sync2
        && s_reg.st_cnt == PWR_SETTLE |=> lockout)
        else $error("low input at power-up did not lock out");
    a_run_test_entry: assert property (
        s_reg.st == rtmon_pkg::RTMON_ST_RUN && long_open && !fault_detect
        |=> test_active && !safety_switch_output_1)
        else $error("long opening in run did not start a test");
    a_mon_open_off: assert property (
        s_reg.st == rtmon_pkg::RTMON_ST_RUN && mon_open
        |=> !safety_switch_output_1 && !safety_switch_output_2)
        else $error("monitor opening left outputs on");
    a_test_outs_off: assert property (
        test_active |-> !safety_switch_output_1 && !safety_switch_output_2)
        else $error("outputs on during test");
    a_reset_clears: assert property (
        (wait_reset || lockout) && released_long && !fault_detect
        |=> s_reg.st == rtmon_pkg::RTMON_ST_TRIPPED)
        else $error("reset not taken when latched");
    a_no_reset_run: assert property (
        wait_reset && !released_long |=> !safety_switch_output_1)
        else $error("outputs on without reset");
    a_short_ignored: assert property (
        s_reg.st == rtmon_pkg::RTMON_ST_RUN && !long_open && !mon_open
        && beams_clear && !fault_detect |=> !test_active)
        else $error("short opening caused a test");
    a_lock_holds: assert property (
        lockout && !released_long |=> lockout)
        else $error("lockout left without reset");
    a_outs_equal: assert property (
        safety_switch_output_1 == safety_switch_output_2)
        else $error("safety outputs differ");
    // power-up with the loop closed must not lock out
    a_pwrup_high_ok: assert property (
        s_reg.st == rtmon_pkg::RTMON_ST_POWERUP && s_reg.sync2
        && s_reg.st_cnt == PWR_SETTLE |=> !lockout)
        else $error("closed loop at power-up locked out");
    // latching variant drops to wait on a trip
    a_trip_latches: assert property (
        LATCH_MODEL && s_reg.st == rtmon_pkg::RTMON_ST_RUN && !beams_clear
        && !mon_open && !long_open && !fault_detect |=> wait_reset)
        else $error("trip did not latch");
    // automatic variant returns once beams are clear
    a_auto_return: assert property (
        !LATCH_MODEL && s_reg.st == rtmon_pkg::RTMON_ST_TRIPPED
        && beams_clear && s_reg.sync2 && !fault_detect
        |=> safety_switch_output_1)
        else $error("automatic outputs did not return");
    // self-test runs its full length
    a_test_min_len: assert property (
        test_active && s_reg.st_cnt != ST_LIM |=> test_active)
        else $error("test cycle cut short");
    // monitoring opening in run without a fault starts a test
    a_mon_test_entry: assert property (
        s_reg.st == rtmon_pkg::RTMON_ST_RUN && mon_open && !fault_detect
        |=> test_active)
        else $error("monitor opening did not start a test");
    // waiting for reset only ends by a reset
    a_wait_holds: assert property (
        wait_reset && !released_long |=> wait_reset)
        else $error("wait state left without reset");

    c_test_seen: cover property (test_active ##1 !test_active);
    c_reset_seen: cover property (wait_reset ##1 !wait_reset);
    c_lock_exit: cover property (lockout ##1 !lockout);
    c_run_seen: cover property (safety_switch_output_1);
    // closed loop at power-up reaches the wait state
    c_pwrup_wait: cover property (
        s_reg.st == rtmon_pkg::RTMON_ST_POWERUP ##1 wait_reset);
endmodule : rtmon_top
`default_nettype wire

// *** rtl/rtmon_pkg.sv ***
// Notes on behaviour
// - one input: reset, remote test, contact monitoring
// - running with outputs on: opening means test
// - latched or locked out: opening means reset
// - input low at power-up forces lockout
// - run mode, open over quarter second: test
// - monitoring opening over 200 ms: test, outputs off
// - latching model: reset needed after trip, lockout
// - automatic model: outputs return when beams clear
package rtmon_pkg;
    // timing figures and derived cycle counts
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned OPEN_MIN_MS = 250;
    localparam int unsigned MON_OPEN_MS = 200;
    localparam int unsigned OPEN_MIN_CYC = OPEN_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned MON_OPEN_CYC = MON_OPEN_MS * (CLK_HZ / 1000);
    localparam int unsigned SELFTEST_CYC = 16;
    localparam int unsigned SYNC_SETTLE_CYC = 2;
    localparam int unsigned CNT_W = 23;
    // system states
    typedef enum logic [2:0] {
        RTMON_ST_POWERUP,
        RTMON_ST_WAIT_RESET,
        RTMON_ST_RUN,
        RTMON_ST_TRIPPED,
        RTMON_ST_TEST,
        RTMON_ST_LOCKOUT
    } rtmon_state_t;
endpackage : rtmon_pkg

// *** rtl/rtmon_open_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtmon_open_timer #(
    parameter int unsigned W = 23
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // synchronised input level
    input wire logic line_high,
    // thresholds in cycles
    input wire logic [W-1:0] long_lim,
    input wire logic [W-1:0] mon_lim,
    // results
    output logic long_open,
    output logic mon_open,
    output logic released_long
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic rel;
    } rtmon_tmr_t;
    rtmon_tmr_t s_reg;
    rtmon_tmr_t s_next;

    // count open time while low; pulse when a long opening closes
    always_comb
    begin
        s_next = s_reg;
        s_next.rel = 1'b0;
        if (!line_high)
        begin
            if (s_reg.cnt != {W{1'b1}})
                s_next.cnt = s_reg.cnt + 1'b1;
        end
        else
        begin
            s_next.rel = (s_reg.cnt >= long_lim);
            s_next.cnt = '0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign long_open = (s_reg.cnt > long_lim);
    assign mon_open = (s_reg.cnt > mon_lim);
    assign released_long = s_reg.rel;
endmodule : rtmon_open_timer
`default_nettype wire

// *** tb/rtmon_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtmon_partner (
    // clock from the bench
    input wire logic core_clk,
    // bench asks the switch or contact loop to open
    input wire logic open_cmd,
    // shared pin, high while the loop is closed
    output logic pin
);
    ////////////////////////////////////////////////////////////////////////
    // loop starts closed so the pin idles high
    initial pin = 1'b1;
    // follow the bench on the rising edge by non-blocking assignment,
    // so the design sees the new level one edge later with no race
    always @(posedge core_clk)
    begin
        pin <= !open_cmd;
    end
endmodule : rtmon_partner
`default_nettype wire

// *** tb/reset_test_monitor_input_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module reset_test_monitor_input_test;
    logic core_clk, rst, pin, open_cmd, beams_clear, fault_detect;
    logic out_1, out_2, test_active, lockout, wait_reset;
    logic auto_1, auto_2;
    int fails = 0;
    int samples_checked = 0;
    ////////////////////////////////////////////////////////////////////////
    // design with shortened opening thresholds
    rtmon_top #(.OPEN_MIN_CYC(20), .MON_OPEN_CYC(16), .LATCH_MODEL(1'b1)) dut (
        .core_clk(core_clk), .rst(rst), .reset_test_in(pin),
        .beams_clear(beams_clear), .fault_detect(fault_detect),
        .safety_switch_output_1(out_1), .safety_switch_output_2(out_2),
        .test_active(test_active), .lockout(lockout),
        .wait_reset(wait_reset));
    // automatic-output variant shares the pin and beam inputs
    rtmon_top #(.OPEN_MIN_CYC(20), .MON_OPEN_CYC(16), .LATCH_MODEL(1'b0))
        dut_auto (
        .core_clk(core_clk), .rst(rst), .reset_test_in(pin),
        .beams_clear(beams_clear), .fault_detect(fault_detect),
        .safety_switch_output_1(auto_1), .safety_switch_output_2(auto_2),
        .test_active(), .lockout(), .wait_reset());
    rtmon_partner sw (.core_clk(core_clk), .open_cmd(open_cmd), .pin(pin));
    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fails++;
        conclude();
    end
    task automatic conclude();
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    // open the loop for n cycles, close, let the decision land
    task automatic open_for(input int n);
        @(negedge core_clk) open_cmd = 1'b1;
        repeat (n) @(negedge core_clk);
        open_cmd = 1'b0;
        repeat (12) @(negedge core_clk);
    endtask : open_for
    task automatic chk_outs(input logic e);
        `CHK(out_1, e)
        `CHK(out_2, e)
    endtask : chk_outs
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    // loop held open through reset, then closed after a short time
    task automatic s_powerup();
        repeat (4) @(negedge core_clk);
        `CHK(lockout, 1'b1)
        chk_outs(1'b0);
        open_cmd = 1'b0;
        repeat (8) @(negedge core_clk);
        `CHK(lockout, 1'b1)
        chk_outs(1'b0);
    endtask : s_powerup
    task automatic s_short_open();
        open_for(10);
        `CHK(lockout, 1'b1)
    endtask : s_short_open
    task automatic s_reset();
        open_for(30);
        `CHK(lockout, 1'b0)
        `CHK(wait_reset, 1'b0)
        chk_outs(1'b1);
    endtask : s_reset
    task automatic s_trip();
        @(negedge core_clk) beams_clear = 1'b0;
        repeat (4) @(negedge core_clk);
        chk_outs(1'b0);
        `CHK(auto_1, 1'b0)
        beams_clear = 1'b1;
        repeat (6) @(negedge core_clk);
        `CHK(wait_reset, 1'b1)
        chk_outs(1'b0);
        `CHK(auto_1, 1'b1)
        `CHK(auto_2, 1'b1)
    endtask : s_trip
    task automatic s_fault();
        @(negedge core_clk) fault_detect = 1'b1;
        @(negedge core_clk) fault_detect = 1'b0;
        repeat (3) @(negedge core_clk);
        `CHK(lockout, 1'b1)
        chk_outs(1'b0);
    endtask : s_fault
    // second power-up with the loop closed: latched waits, automatic runs
    task automatic s_restart();
        @(negedge core_clk) rst = 1'b1;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        `CHK(lockout, 1'b0)
        `CHK(wait_reset, 1'b1)
        chk_outs(1'b0);
        `CHK(auto_1, 1'b1)
        `CHK(auto_2, 1'b1)
    endtask : s_restart
    task automatic s_run_short();
        open_for(12);
        `CHK(test_active, 1'b0)
        chk_outs(1'b1);
    endtask : s_run_short
    task automatic s_test();
        @(negedge core_clk) open_cmd = 1'b1;
        repeat (24) @(negedge core_clk);
        `CHK(test_active, 1'b1)
        `CHK(lockout, 1'b0)
        chk_outs(1'b0);
        open_cmd = 1'b0;
        repeat (8) @(negedge core_clk);
        chk_outs(1'b0);
    endtask : s_test
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        rst = 1'b1;
        // loop open at power-up: must end in lockout
        open_cmd = 1'b1;
        beams_clear = 1'b1;
        fault_detect = 1'b0;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        s_powerup();
        s_short_open();
        s_reset();
        s_trip();
        s_reset();
        s_fault();
        s_reset();
        s_run_short();
        s_test();
        s_restart();
        s_reset();
        conclude();
    end
endmodule : reset_test_monitor_input_test
`default_nettype wire
